//--- rtl/dra_pkg.sv
// Purpose: Shared constants for the digital pin and range alarm block.
// Assumes: 40 MHz core clock, 32-bit AHB-Lite register access.
// Notes: Register offsets are byte addresses, one aligned word each.
// =====================================================================
// Package
package dra_pkg;
	// =================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int DONE_PULSE_NS = 2000;
	// The done pulse is a minimum width, so it rounds up.
	localparam int DONE_PULSE_CYC =
		(DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// =================================================================
	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ADC_CTRL = 8'h04;
	localparam logic [7:0] OFS_ALARM = 8'h08;
	localparam logic [7:0] OFS_GPIO = 8'h0C;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_SYNC_LOAD = 8'h14;
	localparam logic [7:0] OFS_THR_BASE = 8'h20;
	localparam logic [7:0] OFS_THR_END = 8'h3C;

	// =================================================================
	// Field positions
	localparam int BIT_DATA_READY = 13;
	localparam int BIT_EXT_TRIG = 5;
	localparam int BIT_AUTO_MODE = 15;
	localparam int POS_FIRST_CH = 4;
	localparam int POS_LAST_CH = 0;
	localparam int POS_FUNC_SEL = 8;

	// =================================================================
	// Reset values
	localparam logic [3:0] RST_FUNC_SEL = 4'hF;
	localparam logic [5:0] RST_LEVEL = 6'h3F;
	localparam logic [11:0] RST_THR_LO = 12'h000;
	localparam logic [11:0] RST_THR_HI = 12'hFFF;
	localparam logic [3:0] RST_FIRST_CH = 4'h0;
	localparam logic [3:0] RST_LAST_CH = 4'h0;
	localparam int NUM_CHECKED = 4;
endpackage : dra_pkg

//--- rtl/dra_pulse.sv
// Purpose: Fixed-width low pulse timer for the conversion-done pin.
// Assumes: A fire during a running pulse restarts it.
// Notes: Busy is a flip-flop output.
`timescale 1ns/1ps
module dra_pulse #(
	parameter int PULSE_CYC = dra_pkg::DONE_PULSE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic fire,
	output logic busy
);
	logic [7:0] cnt_q, cnt_d;
	logic busy_q, busy_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		if (fire) begin
			cnt_d = 8'(PULSE_CYC - 1);
			busy_d = 1'b1;
		end else if (cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
		end else begin
			busy_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign busy = busy_q;
endmodule : dra_pulse

//--- rtl/dra_res_if.sv
// Purpose: Carries converted results to the window checker and alarms back.
// Assumes: One result per valid cycle, index counts within the sweep.
// Notes: Commit marks the moment alarm bits may change.
`timescale 1ns/1ps
interface dra_res_if;
	logic res_valid;
	logic res_checked;
	logic [1:0] res_index;
	logic [11:0] res_data;
	logic commit;
	logic [3:0] alarm;

	modport main (
		output res_valid, res_checked, res_index, res_data, commit,
		input alarm
	);
	modport win (
		input res_valid, res_checked, res_index, res_data, commit,
		output alarm
	);
endinterface : dra_res_if

//--- rtl/dra_top.sv
// Purpose: Digital pins, trigger inputs and range alarms of the monitor.
// Assumes: Pin inputs synchronous to core_clk; zero-wait AHB-Lite slave.
// Notes: The converter itself sits outside and reports results here.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module dra_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter sequencer
	input wire logic adc_result_valid,
	input wire logic [11:0] adc_result_data,
	input wire logic adc_sweep_done,
	output logic adc_start,
	output logic adc_auto,
	output logic [3:0] adc_first_ch,
	output logic [3:0] adc_last_ch,
	// Trigger and DAC load pins
	input wire logic ext_trigger_pin,
	input wire logic dac_sync_load_pin,
	output logic [7:0] dac_load_strobe,
	// Status pins
	output logic conversion_done_pin_n,
	output logic global_alarm_out_n,
	// General pins
	input wire logic [5:0] gpio_in,
	output logic [5:0] gpio_out,
	output logic [5:0] gpio_oe
);
	dra_res_if res ();

	// =================================================================
	// Bus state
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q, hresp_q;
	logic accept, rd_accept, wr_now;
	logic [31:0] rd_word;

	// =================================================================
	// Configuration and pin state
	logic ctrl_auto_q, ctrl_auto_d;
	logic [3:0] first_ch_q, first_ch_d;
	logic [3:0] last_ch_q, last_ch_d;
	logic ext_en_q, ext_en_d;
	logic [3:0] fsel_q, fsel_d;
	logic [5:0] level_q, level_d;
	logic [7:0] sync_sel_q, sync_sel_d;
	logic [3:0][11:0] thr_lo_q, thr_lo_d;
	logic [3:0][11:0] thr_hi_q, thr_hi_d;
	logic data_ready_q, data_ready_d;
	logic [11:0] data_q, data_d;
	logic [2:0] res_cnt_q, res_cnt_d;
	logic trig_prev_q, load_prev_q;
	logic start_q, start_d;
	logic [7:0] load_strobe_q, load_strobe_d;
	logic done_n_q, done_n_d, global_alarm_out_n_q, global_alarm_out_n_d;
	logic [5:0] gpio_oe_q, gpio_oe_d;
	logic [5:0] gpio_out_q;
	logic auto_mode, trig_rise, load_rise, sweep_direct, sweep_auto;
	logic pulse_busy;
	logic [5:0] level_view;

	// =================================================================
	// Address helpers
	function automatic logic thr_hit(input logic [7:0] a);
		thr_hit = (a >= dra_pkg::OFS_THR_BASE) &&
			(a <= dra_pkg::OFS_THR_END) && (a[1:0] == 2'b00);
	endfunction : thr_hit

	function automatic logic [1:0] thr_idx(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - dra_pkg::OFS_THR_BASE;
		thr_idx = rel[4:3];
	endfunction : thr_idx

	// =================================================================
	// Bus decode
	assign accept = hsel && hready && htrans[1];
	assign rd_accept = accept && !hwrite;
	assign wr_now = wr_pend_q;

	// Pins in alarm role show the inverted alarm, others the pin itself.
	always_comb begin
		level_view = gpio_in;
		for (int i = 0; i < dra_pkg::NUM_CHECKED; i++) begin
			if (!fsel_q[i]) begin
				level_view[i] = !res.alarm[i];
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (haddr[7:0] == dra_pkg::OFS_STATUS) begin
			rd_word[dra_pkg::BIT_DATA_READY] = data_ready_q;
			rd_word[dra_pkg::BIT_EXT_TRIG] = ext_en_q;
		end else if (haddr[7:0] == dra_pkg::OFS_ADC_CTRL) begin
			rd_word[dra_pkg::BIT_AUTO_MODE] = ctrl_auto_q;
			rd_word[dra_pkg::POS_FIRST_CH +: 4] = first_ch_q;
			rd_word[dra_pkg::POS_LAST_CH +: 4] = last_ch_q;
		end else if (haddr[7:0] == dra_pkg::OFS_ALARM) begin
			rd_word[3:0] = res.alarm;
		end else if (haddr[7:0] == dra_pkg::OFS_GPIO) begin
			rd_word[dra_pkg::POS_FUNC_SEL +: 4] = fsel_q;
			rd_word[5:0] = level_view;
		end else if (haddr[7:0] == dra_pkg::OFS_DATA) begin
			rd_word[11:0] = data_q;
		end else if (haddr[7:0] == dra_pkg::OFS_SYNC_LOAD) begin
			rd_word[7:0] = sync_sel_q;
		end else if (thr_hit(haddr[7:0])) begin
			rd_word[11:0] = haddr[2] ? thr_hi_q[thr_idx(haddr[7:0])] :
				thr_lo_q[thr_idx(haddr[7:0])];
		end
	end

	always_comb begin
		wr_pend_d = accept && hwrite;
		wr_addr_d = accept ? haddr[7:0] : wr_addr_q;
		hrdata_d = rd_accept ? rd_word : 32'h0000_0000;
	end

	// Every transfer completes with no wait state and an OKAY answer.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// =================================================================
	// Conversion control and pins
	assign auto_mode = ctrl_auto_q && !ext_en_q;
	assign trig_rise = ext_trigger_pin && !trig_prev_q;
	assign load_rise = dac_sync_load_pin && !load_prev_q;
	assign sweep_direct = adc_sweep_done && !auto_mode;
	assign sweep_auto = adc_sweep_done && auto_mode;

	always_comb begin
		ctrl_auto_d = ctrl_auto_q;
		first_ch_d = first_ch_q;
		last_ch_d = last_ch_q;
		ext_en_d = ext_en_q;
		fsel_d = fsel_q;
		level_d = level_q;
		sync_sel_d = sync_sel_q;
		thr_lo_d = thr_lo_q;
		thr_hi_d = thr_hi_q;
		data_ready_d = data_ready_q;
		start_d = 1'b0;
		if (wr_now) begin
			if (wr_addr_q == dra_pkg::OFS_STATUS) begin
				ext_en_d = hwdata[dra_pkg::BIT_EXT_TRIG];
				if (!hwdata[dra_pkg::BIT_DATA_READY]) begin
					data_ready_d = 1'b0;
				end
			end else if (wr_addr_q == dra_pkg::OFS_ADC_CTRL) begin
				ctrl_auto_d = hwdata[dra_pkg::BIT_AUTO_MODE];
				first_ch_d = hwdata[dra_pkg::POS_FIRST_CH +: 4];
				last_ch_d = hwdata[dra_pkg::POS_LAST_CH +: 4];
				// Under external trigger a write only names the group.
				start_d = !ext_en_q;
			end else if (wr_addr_q == dra_pkg::OFS_GPIO) begin
				fsel_d = hwdata[dra_pkg::POS_FUNC_SEL +: 4];
				level_d = hwdata[5:0];
			end else if (wr_addr_q == dra_pkg::OFS_SYNC_LOAD) begin
				sync_sel_d = hwdata[7:0];
			end else if (thr_hit(wr_addr_q)) begin
				if (wr_addr_q[2]) begin
					thr_hi_d[thr_idx(wr_addr_q)] = hwdata[11:0];
				end else begin
					thr_lo_d[thr_idx(wr_addr_q)] = hwdata[11:0];
				end
			end
		end
		if (ext_en_q && trig_rise) begin
			start_d = 1'b1;
		end
		if (start_d || (rd_accept && haddr[7:0] == dra_pkg::OFS_DATA)) begin
			data_ready_d = 1'b0;
		end
		if (auto_mode) begin
			data_ready_d = 1'b0;
		end else if (sweep_direct) begin
			// A completion in the same cycle as a clear still counts.
			data_ready_d = 1'b1;
		end
	end

	always_comb begin
		data_d = adc_result_valid ? adc_result_data : data_q;
		res_cnt_d = res_cnt_q;
		if (start_q || adc_sweep_done) begin
			res_cnt_d = 3'd0;
		end else if (adc_result_valid && res_cnt_q != 3'd4) begin
			res_cnt_d = res_cnt_q + 3'd1;
		end
		load_strobe_d = load_rise ? sync_sel_q : 8'h00;
		done_n_d = !(data_ready_q || pulse_busy);
		global_alarm_out_n_d = !(|res.alarm);
		gpio_oe_d = ~level_q;
		for (int i = 0; i < dra_pkg::NUM_CHECKED; i++) begin
			if (!fsel_q[i]) begin
				gpio_oe_d[i] = res.alarm[i];
			end
		end
	end

	// Results are numbered by sweep position, not by channel address.
	always_comb begin
		res.res_valid = adc_result_valid;
		res.res_checked = res_cnt_q < 3'd4;
		res.res_index = res_cnt_q[1:0];
		res.res_data = adc_result_data;
		// Alarms move with the ready flag or with the start of the pulse.
		res.commit = sweep_direct || sweep_auto;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_auto_q <= 1'b0;
			first_ch_q <= dra_pkg::RST_FIRST_CH;
			last_ch_q <= dra_pkg::RST_LAST_CH;
			ext_en_q <= 1'b0;
			fsel_q <= dra_pkg::RST_FUNC_SEL;
			level_q <= dra_pkg::RST_LEVEL;
			sync_sel_q <= 8'h00;
			thr_lo_q <= {4{dra_pkg::RST_THR_LO}};
			thr_hi_q <= {4{dra_pkg::RST_THR_HI}};
			data_ready_q <= 1'b0;
			data_q <= 12'h000;
			res_cnt_q <= 3'd0;
			trig_prev_q <= 1'b0;
			load_prev_q <= 1'b0;
			start_q <= 1'b0;
			load_strobe_q <= 8'h00;
			done_n_q <= 1'b1;
			global_alarm_out_n_q <= 1'b1;
			gpio_oe_q <= 6'h00;
			gpio_out_q <= 6'h00;
		end else begin
			ctrl_auto_q <= ctrl_auto_d;
			first_ch_q <= first_ch_d;
			last_ch_q <= last_ch_d;
			ext_en_q <= ext_en_d;
			fsel_q <= fsel_d;
			level_q <= level_d;
			sync_sel_q <= sync_sel_d;
			thr_lo_q <= thr_lo_d;
			thr_hi_q <= thr_hi_d;
			data_ready_q <= data_ready_d;
			data_q <= data_d;
			res_cnt_q <= res_cnt_d;
			trig_prev_q <= ext_trigger_pin;
			load_prev_q <= dac_sync_load_pin;
			start_q <= start_d;
			load_strobe_q <= load_strobe_d;
			done_n_q <= done_n_d;
			global_alarm_out_n_q <= global_alarm_out_n_d;
			gpio_oe_q <= gpio_oe_d;
			gpio_out_q <= 6'h00;
		end
	end

	// =================================================================
	// Submodules
	dra_pulse #(
		.PULSE_CYC(dra_pkg::DONE_PULSE_CYC)
	) u_pulse (
		.core_clk(core_clk),
		.rst(rst),
		.fire(sweep_auto),
		.busy(pulse_busy)
	);

	dra_window u_window (
		.core_clk(core_clk),
		.rst(rst),
		.thr_lo(thr_lo_q),
		.thr_hi(thr_hi_q),
		.res(res)
	);

	// =================================================================
	// Outputs
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign adc_start = start_q;
	assign adc_auto = ctrl_auto_q;
	assign adc_first_ch = first_ch_q;
	assign adc_last_ch = last_ch_q;
	assign dac_load_strobe = load_strobe_q;
	assign conversion_done_pin_n = done_n_q;
	assign global_alarm_out_n = global_alarm_out_n_q;
	assign gpio_out = gpio_out_q;
	assign gpio_oe = gpio_oe_q;
endmodule : dra_top

//--- rtl/dra_window.sv
// Purpose: Window comparison of the first four results and alarm holding.
// Assumes: Thresholds are stable while a sweep is in progress.
// Notes: Pending results reach the alarm bits only on commit.
`timescale 1ns/1ps
module dra_window (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Thresholds
	input wire logic [3:0][11:0] thr_lo,
	input wire logic [3:0][11:0] thr_hi,
	// Results and alarms
	dra_res_if.win res
);
	logic [3:0] pending_q, pending_d;
	logic [3:0] alarm_q, alarm_d;
	logic out_of_range;

	// Equal to a bound counts as inside; an inverted window always trips.
	assign out_of_range = (res.res_data < thr_lo[res.res_index]) ||
		(res.res_data > thr_hi[res.res_index]);

	always_comb begin
		pending_d = pending_q;
		alarm_d = alarm_q;
		if (res.res_valid && res.res_checked) begin
			pending_d[res.res_index] = out_of_range;
		end
		if (res.commit) begin
			// Indices not converted in this sweep read as in range.
			alarm_d = pending_d;
			pending_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pending_q <= '0;
			alarm_q <= '0;
		end else begin
			pending_q <= pending_d;
			alarm_q <= alarm_d;
		end
	end

	assign res.alarm = alarm_q;
endmodule : dra_window

//--- verif/dra_conv_model.sv
// Purpose: Behavioural converter sequencer that feeds results to the block.
// Assumes: Channel values come from the bench; last channel >= first.
// Notes: Auto sweeps repeat after GAP cycles, longer than the done pulse.
`timescale 1ns/1ps
module dra_conv_model #(
	parameter int GAP = 100
) (
	// Clock
	input wire logic core_clk,
	// Control from the block
	input wire logic adc_start,
	input wire logic adc_auto,
	input wire logic [3:0] adc_first_ch,
	input wire logic [3:0] adc_last_ch,
	// Channel values
	input wire logic [7:0][11:0] ch_val,
	// Results
	output logic adc_result_valid,
	output logic [11:0] adc_result_data,
	output logic adc_sweep_done
);
	logic pend;
	// A start seen while busy is kept, so no request is lost.
	task step;
		@(posedge core_clk);
		if (adc_start === 1'h1) pend = 1'h1;
	endtask : step
	task sweep;
		for (int i = 0; i <= int'(adc_last_ch) - int'(adc_first_ch); i++) begin
			step;
			adc_result_valid <= 1'h1;
			adc_result_data <= ch_val[3'(adc_first_ch + 4'(i))];
			step;
			adc_result_valid <= 1'h0;
			// A released data bus carries junk, never the held result.
			adc_result_data <= ~adc_result_data;
		end
		step;
		adc_sweep_done <= 1'h1;
		step;
		adc_sweep_done <= 1'h0;
	endtask : sweep
	initial begin
		adc_result_valid = 1'h0;
		adc_result_data = 12'h000;
		adc_sweep_done = 1'h0;
		pend = 1'h0;
		forever begin
			step;
			if (pend) begin
				pend = 1'h0;
				sweep;
				if (adc_auto === 1'h1) begin
					repeat (GAP) step;
					pend = pend | adc_auto;
				end
			end
		end
	end
endmodule : dra_conv_model

//--- verif/dra_top_assertions.sv
// Purpose: Port-level checks of the digital pin and range alarm block.
// Assumes: One core_clk domain with synchronous active-high rst.
// Notes: Bound to dra_top; sees only its ports.
`timescale 1ns/1ps
module dra_top_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Converter and pins
	input wire logic adc_sweep_done,
	input wire logic adc_auto,
	input wire logic dac_sync_load_pin,
	input wire logic [7:0] dac_load_strobe,
	input wire logic conversion_done_pin_n,
	input wire logic global_alarm_out_n,
	input wire logic [5:0] gpio_out,
	input wire logic [5:0] gpio_oe
);
	// =================================================================
	// Helper logic
	// Counts the cycles the done pin has spent low, to judge pulse width.
	logic [7:0] low_cnt_q;
	logic [7:0] low_cnt_d;
	always_comb begin
		low_cnt_d = conversion_done_pin_n ? 8'h00 : low_cnt_q + 8'h01;
	end
	always_ff @(posedge core_clk) begin
		low_cnt_q <= rst ? 8'h00 : low_cnt_d;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// =================================================================
	// Properties
	property p_rst_pins;
		disable iff (1'h0) rst |=> conversion_done_pin_n && gpio_oe == 6'h00;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins not released after reset");
	property p_rst_alarm;
		disable iff (1'h0) rst |=> global_alarm_out_n;
	endproperty
	a_rst_alarm: assert property (p_rst_alarm)
		else $error("global alarm active after reset");
	property p_dac_cause;
		dac_load_strobe != 8'h00 |->
			$past(dac_sync_load_pin) && !$past(dac_sync_load_pin, 2);
	endproperty
	a_dac_cause: assert property (p_dac_cause)
		else $error("load strobe without load pin rising edge");
	property p_dac_once;
		dac_load_strobe != 8'h00 |=> dac_load_strobe == 8'h00;
	endproperty
	a_dac_once: assert property (p_dac_once)
		else $error("load strobe longer than one cycle");
	property p_sweep_done;
		adc_sweep_done |-> ##[1:3] !conversion_done_pin_n;
	endproperty
	a_sweep_done: assert property (p_sweep_done)
		else $error("done pin not low after sweep");
	property p_pulse_width;
		$rose(conversion_done_pin_n) && adc_auto |->
			int'(low_cnt_q) == dra_pkg::DONE_PULSE_CYC;
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("auto done pulse has wrong width");
	property p_alarm_moment;
		$changed(global_alarm_out_n) |-> $past(rst) || $past(adc_sweep_done)
			|| $past(adc_sweep_done, 2) || $past(adc_sweep_done, 3);
	endproperty
	a_alarm_moment: assert property (p_alarm_moment)
		else $error("global alarm changed away from a sweep end");
	property p_open_drain;
		gpio_out == 6'h00;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pin driven high");
endmodule : dra_top_assertions

bind dra_top dra_top_assertions i_dra_top_assertions (
	.core_clk, .rst, .adc_sweep_done, .adc_auto, .dac_sync_load_pin,
	.dac_load_strobe, .conversion_done_pin_n, .global_alarm_out_n,
	.gpio_out, .gpio_oe
);

//--- verif/dra_top_tb.sv
// Purpose: Self-checking bench for the digital pin and range alarm block.
// Assumes: Zero-wait AHB-Lite slave; pins have pull-ups.
// Notes: The bench plays the host and drives trigger and load pins.
`timescale 1ns/1ps
module dra_top_tb;
	// =================================================================
	// Signals
	logic core_clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic res_valid, sweep_done, adc_start, adc_auto;
	logic [11:0] res_data;
	logic [3:0] first_ch, last_ch;
	logic ext_trigger_pin, dac_sync_load_pin;
	logic [7:0] dac_load_strobe;
	logic conversion_done_pin_n, global_alarm_out_n;
	logic [5:0] gpio_in, gpio_out, gpio_oe, ext_lvl;
	logic [7:0][11:0] ch_val;
	int miscompares, n_compared;
	assign gpio_in = ext_lvl & ~gpio_oe;

	dra_top i_dra_top (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.adc_result_valid(res_valid), .adc_result_data(res_data),
		.adc_sweep_done(sweep_done), .adc_start, .adc_auto,
		.adc_first_ch(first_ch), .adc_last_ch(last_ch), .ext_trigger_pin,
		.dac_sync_load_pin, .dac_load_strobe, .conversion_done_pin_n,
		.global_alarm_out_n, .gpio_in, .gpio_out, .gpio_oe);
	dra_conv_model i_dra_conv_model (.core_clk, .adc_start, .adc_auto,
		.adc_first_ch(first_ch), .adc_last_ch(last_ch), .ch_val,
		.adc_result_valid(res_valid), .adc_result_data(res_data),
		.adc_sweep_done(sweep_done));

	// =================================================================
	// Shared tasks
	task final_report;
		if (miscompares == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task hang(input string nm);
		chk(nm, 32'h0000_0000, 32'h0000_0001);
		final_report;
	endtask : hang
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'h1 && n < 20);
		if (hreadyout !== 1'h1) hang("bus ready");
	endtask : wait_rdy
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'h0, a, 32'h0000_0000);
		chk(nm, r, e);
		chk("bus response", 32'(hresp), 32'h0000_0000);
	endtask : rd
	task wait_done(input logic v, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (conversion_done_pin_n !== v && n < 3000);
		if (conversion_done_pin_n !== v) hang("done pin wait");
	endtask : wait_done
	task cnt_start(input int c, output int n);
		n = 0;
		repeat (c) begin
			@(posedge core_clk);
			if (adc_start === 1'h1) n++;
		end
	endtask : cnt_start
	function automatic logic [7:0] thr(input int n, input logic hi);
		return dra_pkg::OFS_THR_BASE + 8'(8 * n) + (hi ? 8'h04 : 8'h00);
	endfunction : thr

	// =================================================================
	// Scenarios
	task s_reset;
		wr(8'h40, 32'h0000_FFFF);
		rd(8'h40, 32'h0000_0000, "unmapped");
		rd(dra_pkg::OFS_GPIO, 32'h0000_0F3F, "gpio reset");
		rd(dra_pkg::OFS_ALARM, 32'h0000_0000, "alarm reset");
		rd(thr(0, 1'h1), 32'h0000_0FFF, "upper bound reset");
		chk("pins reset", {global_alarm_out_n, gpio_oe}, 7'h40);
	endtask : s_reset
	task s_gpio;
		ext_lvl <= 6'h1F;
		wr(dra_pkg::OFS_GPIO, 32'h0000_0F2F);
		rd(dra_pkg::OFS_GPIO, 32'h0000_0F0F, "gpio levels");
		chk("gpio drive", gpio_oe, 6'h10);
		ext_lvl <= 6'h3F;
		wr(dra_pkg::OFS_GPIO, 32'h0000_0F3F);
	endtask : s_gpio
	task s_dac;
		int n;
		logic [7:0] s;
		n = 0;
		s = 8'h00;
		wr(dra_pkg::OFS_SYNC_LOAD, 32'h0000_00A5);
		dac_sync_load_pin <= 1'h1;
		repeat (6) begin
			@(posedge core_clk);
			if (dac_load_strobe !== 8'h00) begin
				n++;
				s = dac_load_strobe;
			end
		end
		chk("strobe count", n, 1);
		chk("strobe", s, 8'hA5);
		dac_sync_load_pin <= 1'h0;
	endtask : s_dac
	task s_trig;
		int n;
		wr(dra_pkg::OFS_STATUS, 32'h0000_0020);
		wr(dra_pkg::OFS_ADC_CTRL, 32'h0000_0000);
		cnt_start(8, n);
		chk("start by write", n, 0);
		ext_trigger_pin <= 1'h1;
		cnt_start(6, n);
		chk("start by trigger", n, 1);
		ext_trigger_pin <= 1'h0;
		wait_done(1'h0, n);
		rd(dra_pkg::OFS_STATUS, 32'h0000_2020, "trigger flag");
		wr(dra_pkg::OFS_STATUS, 32'h0000_0000);
		rd(dra_pkg::OFS_STATUS, 32'h0000_0000, "flag write 0");
		chk("done released", conversion_done_pin_n, 1'h1);
	endtask : s_trig
	task s_direct;
		int n;
		wr(thr(1, 1'h0), 32'h0000_0100);
		wr(thr(1, 1'h1), 32'h0000_0200);
		wr(thr(2, 1'h0), 32'h0000_0500);
		wr(thr(2, 1'h1), 32'h0000_0400);
		wr(thr(3, 1'h0), 32'h0000_0010);
		wr(thr(3, 1'h1), 32'h0000_0300);
		wr(dra_pkg::OFS_ADC_CTRL, 32'h0000_0047);
		wait_done(1'h0, n);
		rd(dra_pkg::OFS_STATUS, 32'h0000_2000, "ready flag");
		rd(dra_pkg::OFS_ALARM, 32'h0000_0006, "alarms");
		chk("global alarm", global_alarm_out_n, 1'h0);
		wr(dra_pkg::OFS_GPIO, 32'h0000_003F);
		rd(dra_pkg::OFS_GPIO, 32'h0000_0039, "alarm levels");
		chk("alarm pins", gpio_oe, 6'h06);
		rd(dra_pkg::OFS_DATA, 32'h0000_0300, "last result");
		rd(dra_pkg::OFS_STATUS, 32'h0000_0000, "flag after read");
		wr(thr(2, 1'h0), 32'h0000_0000);
		wr(thr(2, 1'h1), 32'h0000_0FFF);
		rd(dra_pkg::OFS_ALARM, 32'h0000_0006, "alarm hold");
		wr(dra_pkg::OFS_ADC_CTRL, 32'h0000_0000);
		wait_done(1'h0, n);
		rd(dra_pkg::OFS_ALARM, 32'h0000_0000, "excluded");
		chk("released", {global_alarm_out_n, gpio_oe}, 7'h40);
	endtask : s_direct
	task s_auto;
		int n;
		rd(dra_pkg::OFS_DATA, 32'h0000_0123, "single result");
		wait_done(1'h1, n);
		wr(dra_pkg::OFS_ADC_CTRL, 32'h0000_8047);
		wait_done(1'h0, n);
		wait_done(1'h1, n);
		chk("pulse width", n, dra_pkg::DONE_PULSE_CYC);
		rd(dra_pkg::OFS_ALARM, 32'h0000_0002, "auto alarm");
		ch_val[5] <= 12'h150;
		repeat (2) begin
			wait_done(1'h0, n);
			wait_done(1'h1, n);
		end
		rd(dra_pkg::OFS_ALARM, 32'h0000_0000, "auto clear");
		ch_val[5] <= 12'h300;
		repeat (2) begin
			wait_done(1'h0, n);
			wait_done(1'h1, n);
		end
		chk("auto global", global_alarm_out_n, 1'h0);
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		chk("reset pins", {global_alarm_out_n, gpio_oe}, 7'h40);
		rd(dra_pkg::OFS_ALARM, 32'h0000_0000, "reset alarm");
		rd(dra_pkg::OFS_GPIO, 32'h0000_0F3F, "reset gpio");
	endtask : s_auto

	// =================================================================
	// Clock and main sequence
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		{rst, hsel, hwrite, htrans, haddr, hwdata} = '0;
		rst = 1'h1;
		hsize = 3'h2;
		{ext_trigger_pin, dac_sync_load_pin} = 2'h0;
		ext_lvl = 6'h3F;
		ch_val = '0;
		ch_val[0] = 12'h123;
		ch_val[4] = 12'hFFF;
		ch_val[5] = 12'h300;
		ch_val[6] = 12'h450;
		ch_val[7] = 12'h300;
		miscompares = 0;
		n_compared = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'h0;
		s_reset;
		s_gpio;
		s_dac;
		s_trig;
		s_direct;
		s_auto;
		final_report;
	end
endmodule : dra_top_tb
